//--- core/gauge_pkg.sv
// Shared constants and types of the gauge counter register bank
package gauge_pkg;

   // ----------------------------------------------------------------
   // Register addresses (7-bit command address field)
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_FLASH_COMMAND = 7'h62;
   localparam logic [6:0] ADDR_COUNTER_CLEAR = 7'h63;
   localparam logic [6:0] ADDR_MODE_CONTROL = 7'h64;
   localparam logic [6:0] ADDR_CHARGE_TIME_LOW = 7'h65;
   localparam logic [6:0] ADDR_CHARGE_TIME_HIGH = 7'h66;
   localparam logic [6:0] ADDR_DISCHARGE_TIME_LOW = 7'h67;
   localparam logic [6:0] ADDR_DISCHARGE_TIME_HIGH = 7'h68;
   localparam logic [6:0] ADDR_SELF_DISCHARGE_LOW = 7'h69;
   localparam logic [6:0] ADDR_SELF_DISCHARGE_HIGH = 7'h6A;
   localparam logic [6:0] ADDR_CHARGE_COUNT_LOW = 7'h6B;
   localparam logic [6:0] ADDR_CHARGE_COUNT_HIGH = 7'h6C;
   localparam logic [6:0] ADDR_DISCHARGE_COUNT_LOW = 7'h6D;
   localparam logic [6:0] ADDR_DISCHARGE_COUNT_HIGH = 7'h6E;
   localparam logic [6:0] ADDR_FLASH_PROGRAM_DATA = 7'h6F;
   localparam logic [6:0] ADDR_FLASH_PROGRAM_ADDRESS = 7'h70;
   localparam logic [6:0] ADDR_VOLTAGE_LOW_BYTE = 7'h71;
   localparam logic [6:0] ADDR_VOLTAGE_HIGH_AND_OFFSET = 7'h72;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MODE_PIN_DIRECTION_BIT = 7;
   localparam int MODE_PIN_LEVEL_BIT = 6;
   localparam int MODE_SLOW_CHARGE_BIT = 5;
   localparam int MODE_SLOW_DISCHARGE_BIT = 4;
   localparam int MODE_THRESHOLD_LSB = 1;
   localparam int MODE_POWER_ON_BIT = 0;
   localparam int CLEAR_DISCHARGE_COUNT_BIT = 0;
   localparam int CLEAR_CHARGE_COUNT_BIT = 1;
   localparam int CLEAR_SELF_DISCHARGE_BIT = 2;
   localparam int CLEAR_DISCHARGE_TIME_BIT = 3;
   localparam int CLEAR_CHARGE_TIME_BIT = 4;
   localparam int CLEAR_WIDTH = 5;
   localparam int VOLTAGE_WIDTH = 11;
   localparam int OFFSET_WIDTH = 5;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic RESET_PIN_DIRECTION = 1'b0;
   localparam logic RESET_PIN_LEVEL = 1'b1;
   localparam logic [2:0] RESET_THRESHOLD = 3'h7;
   localparam logic RESET_POWER_ON = 1'b1;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // Flash command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_NONE = 8'h00;
   localparam logic [7:0] CMD_PROGRAM_BYTE = 8'h0F;
   localparam logic [7:0] CMD_POWER_DOWN = 8'hF6;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint CLK_PERIOD_PS = 4000;
   // One time-counter step at the default rate, 0.8789 s
   localparam longint TICK_PERIOD_PS = 64'd878_900_000_000;
   localparam longint TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
   localparam int TICKS_PER_HOUR = 4096;
   localparam int SLOW_COUNTS_PER_HOUR = 16;
   localparam int SLOW_TICKS = TICKS_PER_HOUR / SLOW_COUNTS_PER_HOUR;
   localparam int NOMINAL_LOW_C = 20;
   localparam int NOMINAL_HIGH_C = 30;
   localparam int BAND_STEP_C = 10;
   localparam int MAX_UP_STEPS = 4;
   localparam int MAX_DOWN_STEPS = 3;

   // ----------------------------------------------------------------
   // Carriers and states
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_cmd_t;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } flash_req_t;

   typedef enum logic [1:0] {
      FL_IDLE,
      FL_READ,
      FL_WAIT
   } flash_state_t;

endpackage

//--- core/count_pair.sv
// Sixteen-bit wrapping counter with synchronous clear
module count_pair (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic incr,
   output logic [15:0] count,
   output logic wrap
);
   typedef struct packed {
      logic [15:0] count;
   } pair_state_t;

   pair_state_t st_q;
   pair_state_t st_d;

   always_comb begin
      st_d = st_q;
      if (clear) begin
         st_d.count = 16'h0000;
      end else if (incr) begin
         st_d.count = st_q.count + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign count = st_q.count;
   // Pulses in the step that takes all ones back to zero
   assign wrap = incr & ~clear & (&st_q.count);
endmodule

//--- core/gauge_counter_register_bank.sv
// Register bank and counters of the battery gauge
//
// Notes on behaviour
// - High voltage byte bits 7:3 hold sign-magnitude offset, 8 mV per step.
// - Eleven-bit voltage: high byte bits 2:0 above low byte, 2.44 mV step.
// - Program address register names the flash byte for byte program.
// - Byte program stores flash byte AND program data register.
// - Discharge counter counts discharge quanta, wraps past all ones.
// - Charge counter counts charge quanta, wraps past all ones.
// - A clear request zeroes both bytes of the chosen counter.
// - Self-discharge counts once per hour at 20 to 30 C, also asleep.
// - Rate doubles per 10 C above band, at most 16 per hour.
// - Rate halves per 10 C below band, at least one per eight hours.
// - Asleep, the device wakes briefly to update self-discharge count.
// - Discharge-time counter runs 4096 counts per hour while discharging.
// - Its rollover toggles slow flag; while set it runs 16 per hour.
// - Charge-time counter runs 4096 counts per hour while charging.
// - Its rollover toggles slow flag; while set it runs 16 per hour.
// - Mode bit 7: 1 pin input, 0 open-drain output; resets to 0.
// - Mode bit 6: 1 releases, 0 pulls pin low; resets to 1.
// - Power-down sleeps only below threshold of mode bits 3:1; zero sleeps.
// - Mode bit 0 set by power-on reset; a host write replaces it with the written bit.
// - Clear bit zeroes counter then self-clears; time clear drops slow flag.
// - Command 0x0F programs a byte; command register clears when done.
// - Command 0xF6 sleeps until any edge on the link pin.
module gauge_counter_register_bank
   import gauge_pkg::*;
#(
   parameter longint TICK_CYCLES_P = gauge_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire gauge_pkg::reg_cmd_t reg_cmd,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic discharge_quantum,
   input wire logic charge_quantum,
   input wire logic discharge_active,
   input wire logic charge_active,
   input wire logic sense_below_threshold,
   input wire logic single_wire_link,
   input wire logic signed [7:0] die_temp_c,
   input wire logic adc_valid,
   input wire logic [10:0] adc_result,
   input wire logic [4:0] adc_offset,
   input wire logic [7:0] flash_rd_data,
   input wire logic flash_done,
   output gauge_pkg::flash_req_t flash_req,
   output logic [2:0] sleep_threshold_select,
   output logic sleeping,
   output logic pin_out,
   output logic pin_oe
);
   import gauge_pkg::*;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] link_sync;
      logic link_prev;
      logic [1:0] dis_sync;
      logic [1:0] chg_sync;
      logic [1:0] thr_sync;
      logic pin_dir;
      logic pin_level;
      logic [2:0] threshold;
      logic por;
      logic slow_dis;
      logic slow_chg;
      logic [7:0] prog_data;
      logic [7:0] prog_addr;
      logic [7:0] flash_command;
      logic [CLEAR_WIDTH-1:0] clear;
      logic [7:0] volt_low;
      logic [7:0] volt_high;
      logic [31:0] tick_cnt;
      logic [7:0] dis_div;
      logic [7:0] chg_div;
      logic [15:0] sd_div;
      flash_state_t fl_state;
      flash_req_t fl_req;
      logic asleep;
      logic sleep_out;
      logic [7:0] rd_data;
      logic rd_valid;
      logic pin_oe;
   } state_t;

   state_t st_q;
   state_t st_d;

   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES_P - 1);
   localparam logic [7:0] SLOW_LAST = 8'(SLOW_TICKS - 1);

   // ----------------------------------------------------------------
   // Counter pairs
   // ----------------------------------------------------------------
   logic tick;
   logic dis_time_inc;
   logic chg_time_inc;
   logic sd_inc;
   logic [15:0] sd_period;
   logic [15:0] dis_count;
   logic [15:0] chg_count;
   logic [15:0] sd_count;
   logic [15:0] dis_time;
   logic [15:0] chg_time;
   logic dis_time_wrap;
   logic chg_time_wrap;

   // Ticks of the base timebase per self-discharge count
   function automatic logic [15:0] sd_ticks(input logic signed [7:0] t);
      int up;
      int dn;
      up = 0;
      dn = 0;
      for (int i = 1; i <= MAX_UP_STEPS; i++) begin
         if (int'(t) > NOMINAL_HIGH_C + (i - 1) * BAND_STEP_C) begin
            up = i;
         end
      end
      for (int i = 1; i <= MAX_DOWN_STEPS; i++) begin
         if (int'(t) < NOMINAL_LOW_C - (i - 1) * BAND_STEP_C) begin
            dn = i;
         end
      end
      return 16'((TICKS_PER_HOUR << dn) >> up);
   endfunction

   assign tick = (st_q.tick_cnt == TICK_LAST);
   assign sd_period = sd_ticks(die_temp_c);
   assign sd_inc = tick && (st_q.sd_div >= sd_period - 16'h0001);
   // Fast rate steps on every tick; slow rate every SLOW_TICKS ticks
   assign dis_time_inc = tick && st_q.dis_sync[1] &&
                         (!st_q.slow_dis || st_q.dis_div == SLOW_LAST);
   assign chg_time_inc = tick && st_q.chg_sync[1] &&
                         (!st_q.slow_chg || st_q.chg_div == SLOW_LAST);

   count_pair u_dis_count (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(st_q.clear[CLEAR_DISCHARGE_COUNT_BIT]),
      .incr(discharge_quantum),
      .count(dis_count),
      .wrap()
   );

   count_pair u_chg_count (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(st_q.clear[CLEAR_CHARGE_COUNT_BIT]),
      .incr(charge_quantum),
      .count(chg_count),
      .wrap()
   );

   count_pair u_sd_count (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(st_q.clear[CLEAR_SELF_DISCHARGE_BIT]),
      .incr(sd_inc),
      .count(sd_count),
      .wrap()
   );

   count_pair u_dis_time (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(st_q.clear[CLEAR_DISCHARGE_TIME_BIT]),
      .incr(dis_time_inc),
      .count(dis_time),
      .wrap(dis_time_wrap)
   );

   count_pair u_chg_time (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(st_q.clear[CLEAR_CHARGE_TIME_BIT]),
      .incr(chg_time_inc),
      .count(chg_time),
      .wrap(chg_time_wrap)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic wr;
   logic rd;
   logic [7:0] mode_byte;
   logic [7:0] rd_mux;

   assign wr = reg_cmd.valid && reg_cmd.write;
   assign rd = reg_cmd.valid && !reg_cmd.write;
   assign mode_byte = {st_q.pin_dir, st_q.pin_level, st_q.slow_chg,
                       st_q.slow_dis, st_q.threshold, st_q.por};

   always_comb begin
      unique case (reg_cmd.addr)
         ADDR_FLASH_COMMAND: rd_mux = st_q.flash_command;
         ADDR_COUNTER_CLEAR: rd_mux = {3'h0, st_q.clear};
         ADDR_MODE_CONTROL: rd_mux = mode_byte;
         ADDR_CHARGE_TIME_LOW: rd_mux = chg_time[7:0];
         ADDR_CHARGE_TIME_HIGH: rd_mux = chg_time[15:8];
         ADDR_DISCHARGE_TIME_LOW: rd_mux = dis_time[7:0];
         ADDR_DISCHARGE_TIME_HIGH: rd_mux = dis_time[15:8];
         ADDR_SELF_DISCHARGE_LOW: rd_mux = sd_count[7:0];
         ADDR_SELF_DISCHARGE_HIGH: rd_mux = sd_count[15:8];
         ADDR_CHARGE_COUNT_LOW: rd_mux = chg_count[7:0];
         ADDR_CHARGE_COUNT_HIGH: rd_mux = chg_count[15:8];
         ADDR_DISCHARGE_COUNT_LOW: rd_mux = dis_count[7:0];
         ADDR_DISCHARGE_COUNT_HIGH: rd_mux = dis_count[15:8];
         ADDR_FLASH_PROGRAM_DATA: rd_mux = st_q.prog_data;
         ADDR_FLASH_PROGRAM_ADDRESS: rd_mux = st_q.prog_addr;
         ADDR_VOLTAGE_LOW_BYTE: rd_mux = st_q.volt_low;
         ADDR_VOLTAGE_HIGH_AND_OFFSET: rd_mux = st_q.volt_high;
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      st_d = st_q;

      // Pin inputs pass two flip-flops before use
      st_d.link_sync = {st_q.link_sync[0], single_wire_link};
      st_d.link_prev = st_q.link_sync[1];
      st_d.dis_sync = {st_q.dis_sync[0], discharge_active};
      st_d.chg_sync = {st_q.chg_sync[0], charge_active};
      st_d.thr_sync = {st_q.thr_sync[0], sense_below_threshold};

      // Timebase and dividers
      st_d.tick_cnt = tick ? 32'h0000_0000 : st_q.tick_cnt + 32'h0000_0001;
      if (tick) begin
         st_d.sd_div = sd_inc ? 16'h0000 : st_q.sd_div + 16'h0001;
         if (st_q.dis_sync[1] && st_q.slow_dis) begin
            st_d.dis_div = st_q.dis_div + 8'h01;
         end
         if (st_q.chg_sync[1] && st_q.slow_chg) begin
            st_d.chg_div = st_q.chg_div + 8'h01;
         end
      end

      // Rollover toggles the slow flag: first sets, second clears
      if (dis_time_wrap) begin
         st_d.slow_dis = ~st_q.slow_dis;
         st_d.dis_div = 8'h00;
      end
      if (chg_time_wrap) begin
         st_d.slow_chg = ~st_q.slow_chg;
         st_d.chg_div = 8'h00;
      end
      if (st_q.clear[CLEAR_DISCHARGE_TIME_BIT]) begin
         st_d.slow_dis = 1'b0;
         st_d.dis_div = 8'h00;
      end
      if (st_q.clear[CLEAR_CHARGE_TIME_BIT]) begin
         st_d.slow_chg = 1'b0;
         st_d.chg_div = 8'h00;
      end

      // Clear bits act for one cycle then drop; a new write wins
      st_d.clear = '0;

      // Latest conversion, reported without offset correction
      if (adc_valid) begin
         st_d.volt_low = adc_result[7:0];
         st_d.volt_high = {adc_offset,
                           adc_result[VOLTAGE_WIDTH-1:8]};
      end

      // Flash byte program and power down
      st_d.fl_req.wr = 1'b0;
      unique case (st_q.fl_state)
         FL_IDLE: begin
            if (st_q.flash_command == CMD_PROGRAM_BYTE) begin
               st_d.fl_req.addr = st_q.prog_addr;
               st_d.fl_state = FL_READ;
            end else if (st_q.flash_command == CMD_POWER_DOWN) begin
               if (st_q.threshold == 3'h0 || st_q.thr_sync[1]) begin
                  st_d.asleep = 1'b1;
                  st_d.flash_command = CMD_NONE;
               end
            end else if (st_q.flash_command != CMD_NONE) begin
               // Erase and transfer codes belong to the flash array
               st_d.flash_command = CMD_NONE;
            end
         end
         FL_READ: begin
            st_d.fl_req.wdata = flash_rd_data & st_q.prog_data;
            st_d.fl_req.wr = 1'b1;
            st_d.fl_state = FL_WAIT;
         end
         FL_WAIT: begin
            if (flash_done) begin
               st_d.flash_command = CMD_NONE;
               st_d.fl_state = FL_IDLE;
            end
         end
      endcase

      // Any edge on the link pin ends sleep
      if (st_q.asleep && (st_q.link_sync[1] != st_q.link_prev)) begin
         st_d.asleep = 1'b0;
      end

      // Host writes
      if (wr) begin
         unique case (reg_cmd.addr)
            ADDR_FLASH_COMMAND: begin
               st_d.flash_command = reg_cmd.wdata;
            end
            ADDR_COUNTER_CLEAR: begin
               st_d.clear = reg_cmd.wdata[CLEAR_WIDTH-1:0];
            end
            ADDR_MODE_CONTROL: begin
               st_d.pin_dir = reg_cmd.wdata[MODE_PIN_DIRECTION_BIT];
               st_d.pin_level = reg_cmd.wdata[MODE_PIN_LEVEL_BIT];
               st_d.threshold = reg_cmd.wdata[MODE_THRESHOLD_LSB +: 3];
               st_d.por = reg_cmd.wdata[MODE_POWER_ON_BIT];
            end
            ADDR_FLASH_PROGRAM_DATA: begin
               st_d.prog_data = reg_cmd.wdata;
            end
            ADDR_FLASH_PROGRAM_ADDRESS: begin
               st_d.prog_addr = reg_cmd.wdata;
            end
            default: begin
            end
         endcase
      end

      // Read answer, one cycle after the request
      st_d.rd_valid = rd;
      st_d.rd_data = rd ? rd_mux : st_q.rd_data;

      // Sleep output drops for one cycle on a self-discharge update
      st_d.sleep_out = st_d.asleep && !sd_inc;

      // Open drain pulls low only as an output with level bit clear
      st_d.pin_oe = !st_d.pin_dir && !st_d.pin_level;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.pin_dir <= RESET_PIN_DIRECTION;
         st_q.pin_level <= RESET_PIN_LEVEL;
         st_q.threshold <= RESET_THRESHOLD;
         st_q.por <= RESET_POWER_ON;
         st_q.flash_command <= CMD_NONE;
         st_q.prog_data <= RESET_BYTE;
         st_q.prog_addr <= RESET_BYTE;
         st_q.fl_state <= FL_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rd_data = st_q.rd_data;
   assign rd_valid = st_q.rd_valid;
   assign flash_req = st_q.fl_req;
   assign sleep_threshold_select = st_q.threshold;
   assign sleeping = st_q.sleep_out;
   assign pin_out = 1'b0;
   assign pin_oe = st_q.pin_oe;
endmodule

//--- sim/gauge_chk.sv
// Port-level checks of the gauge counter register bank
module gauge_chk
   import gauge_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire gauge_pkg::reg_cmd_t reg_cmd,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic discharge_quantum,
   input wire logic charge_quantum,
   input wire logic discharge_active,
   input wire logic charge_active,
   input wire logic sense_below_threshold,
   input wire logic single_wire_link,
   input wire logic signed [7:0] die_temp_c,
   input wire logic adc_valid,
   input wire logic [10:0] adc_result,
   input wire logic [4:0] adc_offset,
   input wire logic [7:0] flash_rd_data,
   input wire logic flash_done,
   input wire gauge_pkg::flash_req_t flash_req,
   input wire logic [2:0] sleep_threshold_select,
   input wire logic sleeping,
   input wire logic pin_out,
   input wire logic pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mode_q;
   logic [7:0] fpd_q;
   logic [7:0] fpa_q;
   logic [6:0] wa;
   assign wa = reg_cmd.addr;
   // Shadow of host writes, so outputs can be tied to what was written
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= 8'h4F;
         fpd_q <= 8'h00;
         fpa_q <= 8'h00;
      end else if (reg_cmd.valid && reg_cmd.write) begin
         if (wa == ADDR_MODE_CONTROL) mode_q <= reg_cmd.wdata;
         if (wa == ADDR_FLASH_PROGRAM_DATA) fpd_q <= reg_cmd.wdata;
         if (wa == ADDR_FLASH_PROGRAM_ADDRESS) fpa_q <= reg_cmd.wdata;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_rd_answer;
      reg_cmd.valid && !reg_cmd.write |=> rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read request not answered");
   property p_flash_addr;
      flash_req.wr |-> flash_req.addr == fpa_q;
   endproperty
   a_flash_addr: assert property (p_flash_addr)
      else $error("program address differs from address register");
   property p_flash_data;
      flash_req.wr |-> flash_req.wdata == ($past(flash_rd_data) & fpd_q);
   endproperty
   a_flash_data: assert property (p_flash_data)
      else $error("programmed byte is not the AND of old and data");
   property p_wr_pulse;
      flash_req.wr |=> !flash_req.wr;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("byte program issued twice");
   property p_sleep_gate;
      $rose(sleeping) |-> mode_q[3:1] == 3'h0 || sense_below_threshold;
   endproperty
   a_sleep_gate: assert property (p_sleep_gate)
      else $error("sleep entered above threshold");
   property p_wake;
      sleeping && $changed(single_wire_link) |-> ##[1:8] !sleeping;
   endproperty
   a_wake: assert property (p_wake)
      else $error("link edge did not wake device");
   property p_threshold;
      $stable(mode_q) |-> sleep_threshold_select == mode_q[3:1];
   endproperty
   a_threshold: assert property (p_threshold)
      else $error("threshold output differs from mode bits");
   property p_pin_drive;
      $stable(mode_q) |-> pin_oe == (!mode_q[7] && !mode_q[6]);
   endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("pin drive differs from mode bits");
   c_program: cover property (flash_req.wr);
   c_sleep: cover property ($rose(sleeping));
   c_read: cover property (rd_valid);
endmodule

//--- sim/flash_model.sv
// Flash array model answering byte-program requests
module flash_model
   import gauge_pkg::*;
(
   input wire logic sys_clk,
   input wire gauge_pkg::flash_req_t flash_req,
   input wire logic [7:0] lat,
   output logic [7:0] flash_rd_data,
   output logic flash_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   int wait_n;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'hA5 ^ 8'(i);
      wait_n = 0;
      flash_done = 1'b0;
   end
   assign flash_rd_data = mem[flash_req.addr];
   // Program time follows lat, so prompt and slow arrays are both seen
   always @(posedge sys_clk) begin
      flash_done <= (wait_n == 1);
      if (wait_n > 0) wait_n <= wait_n - 1;
      if (flash_req.wr) begin
         mem[flash_req.addr] <= flash_req.wdata;
         wait_n <= int'(lat);
      end
   end
endmodule

//--- sim/tb_gauge_counter_register_bank.sv
// Self-checking bench of the gauge counter register bank
module tb_gauge_counter_register_bank;
   timeunit 1ns;
   timeprecision 1ps;
   import gauge_pkg::*;
   logic sys_clk, resetn, rd_valid, discharge_quantum, charge_quantum;
   logic discharge_active, charge_active, sense_below_threshold;
   logic single_wire_link, adc_valid, flash_done, sleeping, pin_out, pin_oe;
   logic signed [7:0] die_temp_c;
   logic [10:0] adc_result;
   logic [4:0] adc_offset;
   logic [7:0] rd_data, flash_rd_data, lat, v, a, d, old;
   logic [2:0] sleep_threshold_select;
   logic [15:0] w;
   reg_cmd_t reg_cmd;
   flash_req_t flash_req;
   int fails, comparisons, seed, n, cc;
   gauge_counter_register_bank #(.TICK_CYCLES_P(4))
      gauge_counter_register_bank_i (.*);
   flash_model flash_model_i (.*);
   task chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("Error at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [6:0] ad, input logic [7:0] dt);
      @(negedge sys_clk);
      reg_cmd = '{1'b1, 1'b1, ad, dt};
      @(negedge sys_clk);
      reg_cmd.valid = 1'b0;
   endtask
   task rd(input logic [6:0] ad, output logic [7:0] r);
      @(negedge sys_clk);
      reg_cmd = '{1'b1, 1'b0, ad, 8'h00};
      @(negedge sys_clk);
      reg_cmd.valid = 1'b0;
      chk(rd_valid, 16'h0001);
      r = rd_data;
   endtask
   task rd16(input logic [6:0] ad, output logic [15:0] r);
      rd(ad, r[7:0]);
      rd(7'(ad + 7'h01), r[15:8]);
   endtask
   function logic in_rng(logic [15:0] x, int lo, int hi);
      return x >= lo && x <= hi;
   endfunction
   function logic [15:0] vhigh(logic [4:0] o, logic [10:0] r);
      return {8'h00, o, r[10:8]};
   endfunction
   task final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      #400_000;
      fails++;
      final_report();
   end
   initial begin
      seed = 32'hdba1a263;
      {resetn, discharge_quantum, charge_quantum, adc_valid} = 4'h0;
      {discharge_active, charge_active, sense_below_threshold} = 3'h0;
      {fails, comparisons, cc} = '0;
      reg_cmd = '0;
      single_wire_link = 1'b1;
      die_temp_c = 8'sd25;
      {adc_result, adc_offset} = '0;
      lat = 8'h01;
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      rd(ADDR_MODE_CONTROL, v);
      chk(v, 16'h004F);
      rd(7'h10, v);
      chk(v, 16'h0000);
      wr(ADDR_MODE_CONTROL, 8'h3E);
      rd(ADDR_MODE_CONTROL, v);
      chk(v, 16'h000E);
      chk(pin_oe, 16'h0001);
      chk(pin_out, 16'h0000);
      wr(ADDR_MODE_CONTROL, 8'hC1);
      rd(ADDR_MODE_CONTROL, v);
      chk(v, 16'h00C1);
      chk(pin_oe, 16'h0000);
      $display("test mode done");
      n = 65536 + ($random(seed) & 31);
      die_temp_c = 8'sd70;
      discharge_active = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk);
         discharge_quantum = 1'b1;
         charge_quantum = 1'($random(seed));
         cc += charge_quantum;
      end
      @(negedge sys_clk);
      {discharge_quantum, charge_quantum, discharge_active} = 3'h0;
      die_temp_c = 8'sd25;
      repeat (4) @(negedge sys_clk);
      rd16(ADDR_DISCHARGE_COUNT_LOW, w);
      chk(w, 16'(n));
      rd16(ADDR_CHARGE_COUNT_LOW, w);
      chk(w, 16'(cc));
      rd16(ADDR_SELF_DISCHARGE_LOW, w);
      chk(in_rng(w, n / 1024 - 1, n / 1024), 16'h0001);
      rd16(ADDR_DISCHARGE_TIME_LOW, w);
      chk(in_rng(w, n / 4 - 2, n / 4 + 1), 16'h0001);
      $display("test counters done");
      wr(ADDR_COUNTER_CLEAR, 8'h0F);
      for (int k = 0; k < 4; k++) begin
         rd16(7'(ADDR_DISCHARGE_COUNT_LOW - 2 * k), w);
         chk(w, 16'h0000);
      end
      rd(ADDR_COUNTER_CLEAR, v);
      chk(v, 16'h0000);
      $display("test clear done");
      for (int k = 0; k < 4; k++) begin
         @(negedge sys_clk);
         adc_result = 11'($random(seed));
         adc_offset = 5'($random(seed));
         adc_valid = 1'b1;
         @(negedge sys_clk);
         adc_valid = 1'b0;
         rd(ADDR_VOLTAGE_LOW_BYTE, v);
         chk(v, {8'h00, adc_result[7:0]});
         rd(ADDR_VOLTAGE_HIGH_AND_OFFSET, v);
         chk(v, vhigh(adc_offset, adc_result));
      end
      $display("test voltage done");
      for (int k = 0; k < 2; k++) begin
         lat = (k == 0) ? 8'h01 : 8'h14;
         a = 8'($random(seed));
         d = 8'($random(seed));
         old = flash_model_i.mem[a];
         wr(ADDR_FLASH_PROGRAM_DATA, d);
         wr(ADDR_FLASH_PROGRAM_ADDRESS, a);
         wr(ADDR_FLASH_COMMAND, CMD_PROGRAM_BYTE);
         for (int t = 0; t < 60 && flash_done !== 1'b1; t++)
            @(negedge sys_clk);
         chk(flash_done, 16'h0001);
         rd(ADDR_FLASH_COMMAND, v);
         chk(v, 16'h0000);
         chk(flash_model_i.mem[a], {8'h00, old & d});
         rd(ADDR_FLASH_PROGRAM_ADDRESS, v);
         chk(v, {8'h00, a});
      end
      $display("test flash done");
      wr(ADDR_MODE_CONTROL, 8'h44);
      wr(ADDR_FLASH_COMMAND, CMD_POWER_DOWN);
      repeat (8) @(negedge sys_clk);
      chk(sleeping, 16'h0000);
      rd(ADDR_FLASH_COMMAND, v);
      chk(v, {8'h00, CMD_POWER_DOWN});
      sense_below_threshold = 1'b1;
      for (int t = 0; t < 10 && sleeping !== 1'b1; t++) @(negedge sys_clk);
      chk(sleeping, 16'h0001);
      single_wire_link = 1'b0;
      for (int t = 0; t < 10 && sleeping !== 1'b0; t++) @(negedge sys_clk);
      chk(sleeping, 16'h0000);
      $display("test sleep done");
      final_report();
   end
endmodule
bind gauge_counter_register_bank gauge_chk gauge_chk_i (.*);
